// *** design/ptr_relay.v ***
// Timing relay with AXI4-Lite register access
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "ptr_map.vh"

////////////////////////////////////////////////////////////////////////////
module ptr_relay #(
	parameter TICK_CYC = `PTR_TICK_CYC,
	parameter ADDR_W   = 8
)(
	input  wire              CLK_SYS,
	input  wire              RST_N,
	input  wire [ADDR_W-1:0] AWADDR,
	input  wire              AWVALID,
	output wire              AWREADY,
	input  wire [31:0]       WDATA,
	input  wire [3:0]        WSTRB,
	input  wire              WVALID,
	output wire              WREADY,
	output reg  [1:0]        BRESP,
	output reg               BVALID,
	input  wire              BREADY,
	input  wire [ADDR_W-1:0] ARADDR,
	input  wire              ARVALID,
	output wire              ARREADY,
	output reg  [31:0]       RDATA,
	output reg  [1:0]        RRESP,
	output reg               RVALID,
	input  wire              RREADY,
	output reg               CONTACT,
	output reg  [17:0]       ELAPSED,
	output wire              DISP_EN
);
	// Relay states
	localparam S_IDLE = 3'd0; // Contact open, waiting
	localparam S_TON  = 3'd1; // Timing with contact open
	localparam S_HOLD = 3'd2; // Contact closed, not timing
	localparam S_TOFF = 3'd3; // Timing with contact closed
	localparam S_DONE = 3'd4; // Pulse over, wait trigger release

	////////////////////////////////////////////////////////////////////
	// Register storage and bus state
	reg [`PTR_CTRL_W-1:0] ctrl;    // Coils and configuration
	reg [31:0]            sp1;     // Raw first setpoint operand
	reg [31:0]            sp2;     // Raw second setpoint operand
	reg                   aw_ok;   // Write address held
	reg                   w_ok;    // Write data held
	reg [ADDR_W-1:0]      aw_a;    // Held write address
	reg [31:0]            w_d;     // Held write data
	reg [3:0]             w_s;     // Held byte strobes
	wire                  wr_go;   // Both halves present
	wire [31:0]           w_mask;  // Byte lanes as bit mask
	wire [31:0]           status;  // Live state word

	// Relay state
	reg [2:0]  st;        // Current state
	reg [17:0] el;        // Elapsed units
	reg [17:0] tgt;       // Target units for this phase
	reg        trig_q;    // Trigger one cycle ago
	reg [15:0] lfsr;      // Random source
	reg [13:0] pre;       // Unit prescaler
	reg        ut;        // One unit of time passed
	reg [2:0]  next_st;
	reg [17:0] next_el;
	reg [17:0] next_tgt;
	wire       base_t;    // 5 ms enable

	// Control fields
	wire       trig   = ctrl[`PTR_F_TRIG];
	wire       rcoil  = ctrl[`PTR_F_RST];
	wire       stop   = ctrl[`PTR_F_STOP];
	wire [3:0] mode   = ctrl[`PTR_F_MODE_HI:`PTR_F_MODE_LO];
	wire [1:0] rng    = ctrl[`PTR_F_RNG_HI:`PTR_F_RNG_LO];
	wire       retain = ctrl[`PTR_F_RETAIN];
	wire       run    = ctrl[`PTR_F_RUN];

	// Mode classes
	wire on_m    = (mode == `PTR_M_ON) || (mode == `PTR_M_ON_RND);
	wire rt_m    = (mode == `PTR_M_OFF_RT) ||
	               (mode == `PTR_M_OFF_RT_RND);
	wire off_m   = (mode == `PTR_M_OFF) || (mode == `PTR_M_OFF_RND) ||
	               rt_m;
	wire onoff_m = (mode == `PTR_M_ONOFF) ||
	               (mode == `PTR_M_ONOFF_RND);
	wire pulse_m = (mode == `PTR_M_PULSE);
	wire syn_m   = (mode == `PTR_M_FLASH_SYN);
	wire flash_m = syn_m || (mode == `PTR_M_FLASH_ASY);
	wire rnd_m   = (mode == `PTR_M_ON_RND) || (mode == `PTR_M_OFF_RND) ||
	               (mode == `PTR_M_OFF_RT_RND) ||
	               (mode == `PTR_M_ONOFF_RND);

	assign DISP_EN = ctrl[`PTR_F_DISP];

	////////////////////////////////////////////////////////////////////
	// Setpoint scaling to internal units
	function [17:0] conv;
		input [31:0] raw;
		input [1:0]  r;
		reg   [31:0] c;
		begin
			if (r == `PTR_R_S) begin
				// Cap then round to nearest 5 ms step
				c = (raw > `PTR_S_CAP_MS) ? `PTR_S_CAP_MS : raw;
				c = (c + 32'h2) / `PTR_RES_MS;
			end else begin
				c = (raw > `PTR_U_CAP) ? `PTR_U_CAP : raw;
			end
			conv = c[17:0];
		end
	endfunction

	// Scale a setpoint by the random fraction in random variants
	function [17:0] pick;
		input [17:0] sp;
		input        rnd;
		input [15:0] r;
		reg   [33:0] p;
		begin
			p = sp * r;
			pick = rnd ? p[33:16] : sp;
		end
	endfunction

	wire [17:0] sp1u = conv(sp1, rng);
	wire [17:0] sp2u = conv(sp2, rng);
	wire [17:0] spf  = syn_m ? sp1u : sp2u; // Space time
	wire        done = (el >= tgt);  // Registered state, next-cycle view
	wire        adv  = ut && !stop;  // Stop freezes timing

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel: address and data taken in either order
	assign AWREADY = !aw_ok;
	assign WREADY  = !w_ok;
	assign wr_go   = aw_ok && w_ok && !BVALID;
	assign w_mask  = {{8{w_s[3]}}, {8{w_s[2]}}, {8{w_s[1]}}, {8{w_s[0]}}};

	// Hold each half until both are present, then answer
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			aw_ok <= 1'b0;
			w_ok <= 1'b0;
			aw_a <= {ADDR_W{1'b0}};
			w_d <= 32'h00000000;
			w_s <= 4'h0;
			BVALID <= 1'b0;
			BRESP <= 2'h0;
		end else begin
			if (AWVALID && !aw_ok) begin
				aw_ok <= 1'b1;
				aw_a <= AWADDR;
			end
			if (WVALID && !w_ok) begin
				w_ok <= 1'b1;
				w_d <= WDATA;
				w_s <= WSTRB;
			end
			if (wr_go) begin
				aw_ok <= 1'b0;
				w_ok <= 1'b0;
				BVALID <= 1'b1;
				// Read-only and unmapped words answer with an error
				case (aw_a[7:0])
				`PTR_REG_CTRL, `PTR_REG_SP1, `PTR_REG_SP2: BRESP <= 2'h0;
				default: BRESP <= 2'h2;
				endcase
			end else if (BVALID && BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	// Writable registers, byte lanes honoured
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			ctrl <= `PTR_CTRL_RST; // Run, display enabled
			sp1 <= 32'h00000000;
			sp2 <= 32'h00000000;
		end else if (wr_go) begin
			case (aw_a[7:0])
			`PTR_REG_CTRL: begin
				ctrl <= (ctrl & ~w_mask[`PTR_CTRL_W-1:0]) |
				        (w_d[`PTR_CTRL_W-1:0] & w_mask[`PTR_CTRL_W-1:0]);
			end
			`PTR_REG_SP1: sp1 <= (sp1 & ~w_mask) | (w_d & w_mask);
			`PTR_REG_SP2: sp2 <= (sp2 & ~w_mask) | (w_d & w_mask);
			default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel: one answer per address, next edge
	assign ARREADY = !RVALID;
	assign status  = {25'h0000000, tgt == el, st, 2'h0, CONTACT};

	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			RVALID <= 1'b0;
			RDATA <= 32'h00000000;
			RRESP <= 2'h0;
		end else if (ARVALID && !RVALID) begin
			RVALID <= 1'b1;
			RRESP <= 2'h0;
			case (ARADDR[7:0])
			`PTR_REG_CTRL:    RDATA <= {20'h00000, ctrl};
			`PTR_REG_SP1:     RDATA <= sp1;
			`PTR_REG_SP2:     RDATA <= sp2;
			`PTR_REG_STATUS:  RDATA <= status;
			`PTR_REG_ELAPSED: RDATA <= {14'h0000, el};
			default: begin
				RDATA <= 32'h00000000;
				RRESP <= 2'h2;
			end
			endcase
		end else if (RVALID && RREADY) begin
			RVALID <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Time base: 5 ms tick, scaled per range
	ptr_tick #(
		.DIV (TICK_CYC),
		.CW  (16)
	) u_tick (
		.CLK_SYS (CLK_SYS),
		.RST_N   (RST_N),
		.EN      (run),
		.TICK    (base_t)
	);

	// Prescaler: 1 s or 1 min units outside the seconds range
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			pre <= 14'h0000;
			ut <= 1'b0;
		end else if (!base_t) begin
			ut <= 1'b0;
		end else if (rng == `PTR_R_S) begin
			pre <= 14'h0000;
			ut <= 1'b1;
		end else if (pre == ((rng == `PTR_R_MS) ? `PTR_MS_DIV :
		                     `PTR_HM_DIV) - 14'h0001) begin
			pre <= 14'h0000;
			ut <= 1'b1;
		end else begin
			pre <= pre + 14'h0001;
			ut <= 1'b0;
		end
	end

	// Random source, free-running so draws depend on trigger timing
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			lfsr <= 16'hACE1;
		end else begin
			lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		end
	end

	////////////////////////////////////////////////////////////////////
	// Next-state logic of the relay
	always @* begin
		next_st = st;
		next_el = el;
		next_tgt = tgt;
		case (st)
		S_IDLE: begin
			if ((on_m || onoff_m) && trig && !trig_q) begin
				// Fresh trigger edge needed, also after reset
				next_st = S_TON;
				next_el = 18'h00000;
				next_tgt = pick(sp1u, rnd_m, lfsr);
			end else if (off_m && trig) begin
				// Close with trigger; resumes after reset
				next_st = S_HOLD;
				next_el = 18'h00000;
			end else if ((pulse_m || flash_m) && trig) begin
				next_st = S_TOFF; // Pulse or mark phase
				next_el = 18'h00000;
				next_tgt = sp1u;
			end
		end
		S_TON: begin
			if (!trig) begin
				next_st = S_IDLE; // Early release abandons
				next_el = 18'h00000;
			end else if (done) begin
				if (flash_m) begin
					next_st = S_TOFF; // Space over, mark again
					next_el = 18'h00000;
					next_tgt = sp1u;
				end else begin
					next_st = S_HOLD;
				end
			end else if (adv) begin
				next_el = el + 18'h00001;
			end
		end
		S_HOLD: begin
			if (!trig) begin
				if (onoff_m) begin
					next_st = S_TOFF; // Off-delay from second value
					next_el = 18'h00000;
					next_tgt = pick(sp2u, rnd_m, lfsr);
				end else if (off_m) begin
					next_st = S_TOFF;
					// Keep partial time, draw a target only when fresh
					if (el == 18'h00000) begin
						next_tgt = pick(sp1u, rnd_m, lfsr);
					end
				end else begin
					next_st = S_IDLE;
				end
			end
		end
		S_TOFF: begin
			if (done) begin
				next_el = 18'h00000;
				if (flash_m) begin
					next_st = S_TON; // Mark over, space phase
					next_tgt = spf;
				end else if (pulse_m) begin
					next_st = S_DONE; // Long trigger cannot extend
				end else begin
					next_st = S_IDLE;
				end
			end else if ((off_m || onoff_m) && trig) begin
				next_st = S_HOLD;
				// Retriggerable restarts the full time
				if (rt_m || onoff_m) begin
					next_el = 18'h00000;
				end
			end else if (flash_m && !trig) begin
				next_st = S_IDLE; // Flash only while triggered
				next_el = 18'h00000;
			end else if (adv) begin
				next_el = el + 18'h00001; // Short trigger lengthened
			end
		end
		S_DONE: begin
			if (!trig) begin
				next_st = S_IDLE;
			end
		end
		default: begin
			next_st = S_IDLE;
		end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Relay state registers and outputs
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			st <= S_IDLE;
			el <= 18'h00000;
			tgt <= 18'h00000;
			trig_q <= 1'b0;
			CONTACT <= 1'b0;
			ELAPSED <= 18'h00000;
		end else begin
			trig_q <= trig;
			if (rcoil) begin
				// Reset coil wins over everything
				st <= S_IDLE;
				el <= 18'h00000;
				CONTACT <= 1'b0;
				ELAPSED <= 18'h00000;
			end else if (!run) begin
				// Stop mode: keep value only when retentive
				if (!retain) begin
					st <= S_IDLE;
					el <= 18'h00000;
					CONTACT <= 1'b0;
					ELAPSED <= 18'h00000;
				end
			end else begin
				st <= next_st;
				el <= next_el;
				tgt <= next_tgt;
				// Contact closed while holding or timing closed
				CONTACT <= (next_st == S_HOLD) || (next_st == S_TOFF);
				ELAPSED <= next_el;
			end
		end
	end
endmodule

// *** design/ptr_map.vh ***
// Register map, field positions and timing constants of the timing relay
`ifndef PTR_MAP_VH
`define PTR_MAP_VH

// Byte offsets of the register words
`define PTR_REG_CTRL     8'h00
`define PTR_REG_SP1      8'h04
`define PTR_REG_SP2      8'h08
`define PTR_REG_STATUS   8'h0C
`define PTR_REG_ELAPSED  8'h10

// Control word fields
`define PTR_CTRL_W       12
`define PTR_F_TRIG       0
`define PTR_F_RST        1
`define PTR_F_STOP       2
`define PTR_F_MODE_LO    3
`define PTR_F_MODE_HI    6
`define PTR_F_RNG_LO     7
`define PTR_F_RNG_HI     8
`define PTR_F_RETAIN     9
`define PTR_F_DISP       10
`define PTR_F_RUN        11
`define PTR_CTRL_RST     12'hC00

// Switch functions
`define PTR_M_ON         4'h0
`define PTR_M_ON_RND     4'h1
`define PTR_M_OFF        4'h2
`define PTR_M_OFF_RND    4'h3
`define PTR_M_ONOFF      4'h4
`define PTR_M_OFF_RT     4'h5
`define PTR_M_OFF_RT_RND 4'h6
`define PTR_M_ONOFF_RND  4'h7
`define PTR_M_PULSE      4'h8
`define PTR_M_FLASH_SYN  4'h9
`define PTR_M_FLASH_ASY  4'hA

// Time ranges
`define PTR_R_S          2'h0
`define PTR_R_MS         2'h1
`define PTR_R_HM         2'h2

// Setpoint limits and scaling
`define PTR_S_CAP_MS     32'h000F423B
`define PTR_U_CAP        32'h0000176F
`define PTR_RES_MS       5
`define PTR_MS_DIV       14'h00C8
`define PTR_HM_DIV       14'h2EE0

// Timing: clock rate, base tick in ms, cycles per tick
`define PTR_CLK_HZ       10000000
`define PTR_TICK_MS      5
`define PTR_TICK_CYC     ((`PTR_CLK_HZ / 1000) * `PTR_TICK_MS)

`endif

// *** design/ptr_tick.v ***
// Divider counting while EN is high, giving a one-cycle enable pulse every DIV cycles
`timescale 1ns/1ps
module ptr_tick #(
	parameter DIV = 50000,
	parameter CW  = 16
)(
	input  wire CLK_SYS,
	input  wire RST_N,
	input  wire EN,
	output reg  TICK
);
	reg [CW-1:0] cnt; // Cycles since last pulse

	// Count while enabled; halting keeps the phase for a clean resume
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			cnt <= {CW{1'b0}};
			TICK <= 1'b0;
		end else if (EN) begin
			if (cnt == DIV[CW-1:0] - 1'b1) begin
				cnt <= {CW{1'b0}};
				TICK <= 1'b1;
			end else begin
				cnt <= cnt + 1'b1;
				TICK <= 1'b0;
			end
		end else begin
			TICK <= 1'b0;
		end
	end
endmodule

// *** bench/ptr_chk_asserts.sv ***
// Port checker for the timing relay
`timescale 1ns/1ps
module ptr_chk #(
	parameter TICK_CYC = 4
)(
	input wire        CLK_SYS,
	input wire        RST_N,
	input wire        AWVALID,
	input wire        AWREADY,
	input wire        WVALID,
	input wire        WREADY,
	input wire        BVALID,
	input wire        BREADY,
	input wire [1:0]  BRESP,
	input wire        ARVALID,
	input wire        ARREADY,
	input wire        RVALID,
	input wire        RREADY,
	input wire [31:0] RDATA,
	input wire        CONTACT,
	input wire [17:0] ELAPSED,
	input wire        DISP_EN
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	////////////////////////////////////////////////////////////////////
	// Cycles since the last unit step; clears do not restart it
	int        gap;
	reg [17:0] el_q;
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			gap  <= 0;
			el_q <= 18'h00000;
		end else begin
			el_q <= ELAPSED;
			if (ELAPSED == el_q + 18'h00001)
				gap <= 0;
			else
				gap <= gap + 1;
		end
	end
	////////////////////////////////////////////////////////////////////
	// Both halves of a write taken together
	sequence wr_taken;
		AWVALID && AWREADY && WVALID && WREADY && !BVALID;
	endsequence
	// Answer within two edges
	sequence b_due;
		##[1:2] BVALID;
	endsequence
	aw_hold_a: assert property (AWVALID && AWREADY |=> !AWREADY)
		else $error("address taken twice");
	w_hold_a: assert property (WVALID && WREADY |=> !WREADY)
		else $error("data taken twice");
	b_answer_a: assert property (wr_taken |-> b_due)
		else $error("write answer late");
	b_stand_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write answer dropped");
	r_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
		else $error("read answer late");
	r_stand_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
		else $error("read answer dropped");
	ar_block_a: assert property (RVALID |-> !ARREADY)
		else $error("read taken while busy");
	reset_idle_a: assert property ($rose(RST_N) |->
		!CONTACT && ELAPSED == 18'h00000 && DISP_EN)
		else $error("bad state after reset");
	el_step_a: assert property ($changed(ELAPSED) |->
		ELAPSED == $past(ELAPSED) + 18'h00001 || ELAPSED == 18'h00000)
		else $error("elapsed time jumped");
	tick_space_a: assert property (
		ELAPSED == $past(ELAPSED) + 18'h00001 |-> gap >= TICK_CYC - 1)
		else $error("elapsed time stepped too soon");
endmodule

bind ptr_relay ptr_chk #(.TICK_CYC(TICK_CYC)) ptr_chk_i (
	.CLK_SYS(CLK_SYS), .RST_N(RST_N), .AWVALID(AWVALID),
	.AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
	.BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
	.ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID),
	.RREADY(RREADY), .RDATA(RDATA), .CONTACT(CONTACT),
	.ELAPSED(ELAPSED), .DISP_EN(DISP_EN)
);

// *** bench/ptr_diagram.sv ***
// Diagram-side model reading the contact and timing its phases
`timescale 1ns/1ps
module ptr_diagram (
	input  wire       CLK_SYS,
	input  wire       RST_N,
	input  wire       CONTACT,
	output reg  [7:0] HI_LEN,
	output reg  [7:0] LO_LEN
);
	reg       last;
	reg [7:0] run;
	// Length of the last closed and open spans, in cycles
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			last   <= 1'b0;
			run    <= 8'h00;
			HI_LEN <= 8'h00;
			LO_LEN <= 8'h00;
		end else begin
			last <= CONTACT;
			run  <= (CONTACT != last) ? 8'h01 : run + 8'h01;
			if (CONTACT != last && last)
				HI_LEN <= run;
			if (CONTACT != last && !last)
				LO_LEN <= run;
		end
	end
endmodule

// *** bench/test_programmable_timing_relay.sv ***
// Self-checking bench for the timing relay
`timescale 1ns/1ps
`define CHK(n, e, s) begin \
	n_compared++; \
	if ((s) !== (e)) begin \
		failures++; \
		$display("wrong value %s expected %0h seen %0h", n, e, s); \
	end \
end
module test_programmable_timing_relay;
	localparam TC = 4;
	localparam OK = 2'b00;
	localparam SE = 2'b10;
	logic        CLK_SYS, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
	logic [7:0]  AWADDR, ARADDR;
	logic [31:0] WDATA, d, e1;
	logic [3:0]  WSTRB;
	wire         AWREADY, WREADY, BVALID, ARREADY, RVALID, CONTACT, DISP_EN;
	wire  [1:0]  BRESP, RRESP;
	wire  [31:0] RDATA;
	wire  [17:0] ELAPSED;
	wire  [7:0]  hi_len, lo_len;
	int          failures = 0;
	int          n_compared = 0;
	int          i;
	ptr_relay #(.TICK_CYC(TC)) ptr_relay_i (
		.CLK_SYS(CLK_SYS), .RST_N(RST_N), .AWADDR(AWADDR),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
		.WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
		.BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
		.ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
		.RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.CONTACT(CONTACT), .ELAPSED(ELAPSED), .DISP_EN(DISP_EN)
	);
	ptr_diagram ptr_diagram_i (
		.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CONTACT(CONTACT),
		.HI_LEN(hi_len), .LO_LEN(lo_len)
	);
	initial begin
		CLK_SYS = 1'b0;
		forever #50 CLK_SYS = ~CLK_SYS;
	end
	////////////////////////////////////////////////////////////////////
	// Bus write; each half released once taken
	task wr(input [7:0] a, input [31:0] v, input [1:0] er);
		@(posedge CLK_SYS);
		AWADDR  <= a;
		AWVALID <= 1'b1;
		WDATA   <= v;
		WVALID  <= 1'b1;
		BREADY  <= 1'b1;
		do begin
			@(posedge CLK_SYS);
			if (AWVALID & AWREADY)
				AWVALID <= 1'b0;
			if (WVALID & WREADY)
				WVALID <= 1'b0;
		end while (!(BVALID & BREADY));
		BREADY <= 1'b0;
		`CHK("bresp", er, BRESP)
	endtask
	// Bus read
	task rd(input [7:0] a, output [31:0] v, input [1:0] er);
		@(posedge CLK_SYS);
		ARADDR  <= a;
		ARVALID <= 1'b1;
		RREADY  <= 1'b1;
		do begin
			@(posedge CLK_SYS);
			if (ARVALID & ARREADY)
				ARVALID <= 1'b0;
		end while (!(RVALID & RREADY));
		RREADY <= 1'b0;
		v = RDATA;
		`CHK("rresp", er, RRESP)
	endtask
	// Control word; f is run, retain, stop, reset coil, trigger
	task cw(input [3:0] m, input [1:0] r, input [4:0] f);
		wr(8'h00, {20'h0, f[4], 1'b1, f[3], r, m, f[2:0]}, OK);
	endtask
	task w(input int n);
		repeat (n) @(posedge CLK_SYS);
	endtask
	task results;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	// Watchdog well beyond the expected few thousand cycles
	initial begin
		w(20000);
		failures++;
		results;
	end
	initial begin
		RST_N   = 1'b0;
		AWADDR  = 8'h00;
		AWVALID = 1'b0;
		WDATA   = 32'h00000000;
		WSTRB   = 4'hF;
		WVALID  = 1'b0;
		BREADY  = 1'b0;
		ARADDR  = 8'h00;
		ARVALID = 1'b0;
		RREADY  = 1'b0;
		w(3);
		RST_N <= 1'b1;
		rd(8'h00, d, OK);
		`CHK("ctrl", 32'h00000C00, d)
		wr(8'h00, 32'h00000000, OK);
		`CHK("disp", 1'b0, DISP_EN)
		wr(8'h10, 32'h00000001, SE);
		wr(8'h20, 32'h00000001, SE);
		rd(8'h24, d, SE);
		`CHK("unmapped", 32'h00000000, d)
		// 23 ms rounds to 25 ms, five units
		wr(8'h04, 32'd23, OK);
		cw(4'h0, 2'h0, 5'b10001);
		w(12);
		`CHK("on early", 1'b0, CONTACT)
		w(20);
		`CHK("on late", 1'b1, CONTACT)
		`CHK("units", 18'd5, ELAPSED)
		cw(4'h0, 2'h0, 5'b10101);
		w(8);
		`CHK("stop after", 1'b1, CONTACT)
		cw(4'h0, 2'h0, 5'b10011);
		w(2);
		`CHK("rst open", 1'b0, CONTACT)
		`CHK("rst clear", 18'd0, ELAPSED)
		cw(4'h0, 2'h0, 5'b10001);
		w(40);
		`CHK("await trig", 1'b0, CONTACT)
		cw(4'h0, 2'h0, 5'b10000);
		cw(4'h0, 2'h0, 5'b10001);
		w(6);
		cw(4'h0, 2'h0, 5'b10000);
		w(30);
		`CHK("released", 1'b0, CONTACT)
		// Trigger rises while stopped
		cw(4'h0, 2'h0, 5'b10100);
		cw(4'h0, 2'h0, 5'b10101);
		w(40);
		`CHK("stopped", 18'd0, ELAPSED)
		cw(4'h0, 2'h0, 5'b10001);
		w(32);
		`CHK("resumed", 1'b1, CONTACT)
		// One second in minutes range
		wr(8'h04, 32'd1, OK);
		cw(4'h0, 2'h1, 5'b10000);
		cw(4'h0, 2'h1, 5'b10001);
		w(700);
		`CHK("ms early", 1'b0, CONTACT)
		w(140);
		`CHK("ms late", 1'b1, CONTACT)
		// Two drop-outs: sum expires, retrigger does not
		wr(8'h04, 32'd40, OK);
		// Reset coil clears the hold and count left by the on-delay
		cw(4'h2, 2'h0, 5'b10010);
		for (i = 0; i < 2; i++) begin
			cw(i ? 4'h5 : 4'h2, 2'h0, 5'b10001);
			w(4);
			`CHK("off close", 1'b1, CONTACT)
			cw(i ? 4'h5 : 4'h2, 2'h0, 5'b10000);
			w(16);
			cw(i ? 4'h5 : 4'h2, 2'h0, 5'b10001);
			w(4);
			cw(i ? 4'h5 : 4'h2, 2'h0, 5'b10000);
			w(22);
			`CHK("drop sum", i, CONTACT)
			w(40);
			`CHK("off open", 1'b0, CONTACT)
		end
		cw(4'h2, 2'h0, 5'b10011);
		w(2);
		`CHK("off rst", 1'b0, CONTACT)
		cw(4'h2, 2'h0, 5'b10001);
		w(4);
		`CHK("off again", 1'b1, CONTACT)
		cw(4'h2, 2'h0, 5'b10000);
		w(40);
		// Short trigger stretched, long one not
		cw(4'h8, 2'h0, 5'b10001);
		cw(4'h8, 2'h0, 5'b10000);
		w(16);
		`CHK("pulse on", 1'b1, CONTACT)
		w(24);
		`CHK("pulse off", 1'b0, CONTACT)
		cw(4'h8, 2'h0, 5'b10001);
		w(44);
		`CHK("pulse fix", 1'b0, CONTACT)
		// Freeze in stop with trigger held high, then resume
		cw(4'h0, 2'h0, 5'b10000);
		cw(4'h0, 2'h0, 5'b10001);
		w(12);
		cw(4'h0, 2'h0, 5'b01001);
		rd(8'h10, e1, OK);
		`CHK("el reg", ELAPSED, e1[17:0])
		// Fifteen edges of timing at one unit per four cycles
		`CHK("el frozen", 1'b1, e1 inside {[3:4]})
		w(40);
		rd(8'h10, d, OK);
		`CHK("retained", e1, d)
		cw(4'h0, 2'h0, 5'b11001);
		w(28);
		`CHK("retain end", 1'b1, CONTACT)
		// Mark 8 ms rounds to two units, 16 ms rounds to three units of space
		wr(8'h04, 32'd8, OK);
		wr(8'h08, 32'd16, OK);
		// Trigger drops first so the closed hold is left
		cw(4'hA, 2'h0, 5'b10000);
		cw(4'hA, 2'h0, 5'b10001);
		w(80);
		`CHK("mark", 1'b1, hi_len inside {[2*TC-1:2*TC+1]})
		`CHK("space", 1'b1, lo_len inside {[3*TC-1:3*TC+1]})
		cw(4'hA, 2'h0, 5'b10000);
		// Sync flash uses the first value for both phases
		cw(4'h9, 2'h0, 5'b10001);
		w(80);
		`CHK("syn mark", 1'b1, hi_len inside {[2*TC-1:2*TC+1]})
		`CHK("syn space", 1'b1, lo_len inside {[2*TC-1:2*TC+1]})
		cw(4'h9, 2'h0, 5'b10000);
		// On-delay two units, off-delay three, stop holds the off phase
		cw(4'h4, 2'h0, 5'b10001);
		w(4);
		`CHK("onoff early", 1'b0, CONTACT)
		w(16);
		`CHK("onoff on", 1'b1, CONTACT)
		cw(4'h4, 2'h0, 5'b10100);
		w(40);
		`CHK("onoff stop", 1'b1, CONTACT)
		`CHK("onoff held", 18'd0, ELAPSED)
		cw(4'h4, 2'h0, 5'b10000);
		w(24);
		`CHK("onoff off", 1'b0, CONTACT)
		// Random on-delay closes before the full two units
		cw(4'h1, 2'h0, 5'b10001);
		w(20);
		`CHK("rnd on", 1'b1, CONTACT)
		`CHK("rnd short", 1'b1, ELAPSED < 18'd2)
		results;
	end
endmodule
